// *** design/ebs_seq.sv ***
/*
  External bus strobe sequencer: lead, active and trail phases of
  external reads and writes, aligned to a generated bus clock.
  Assumes AHB-Lite register access and an external memory on the pins.
*/
// What this block does
// - Phases counted in access timing clock cycles.
// - Strobes and zone change on timing edges.
// - Bus clock at full or half rate.
// - Full rate: strobes change on rising edge.
// - Half rate: even count rising, odd falling.
// - Zone low and write flag rise-aligned.
// - Strobe assertion aligns by lead parity.
// - Strobe release aligns by lead-plus-active parity.
// - Access end aligns by total cycle parity.
// - Access starts on rising edge, aligning first.
// - Alignment cycles keep all controls inactive.
// - Address bus holds last address when inactive.
// - Ready ignored when honor setting clear.
// - New address driven at access start edge.
// - Write data from strobe until one tick after flag high.
// - Write data held through write trail.
// - Phase lengths from counts, doubling, wait states.
// - Synchronous ready sampled after lead plus active.
// - Asynchronous ready sampled two cycles earlier.
`default_nettype none
`include "ebs_defs.svh"

module ebs_seq
  import ebs_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  output logic             OUTPUT_BUS_CLOCK,
  output logic             ZONE_SELECT_N,
  output logic             READ_STROBE_N,
  output logic             WRITE_STROBE_N,
  output logic             READ_NOT_WRITE,
  output logic [18:0]      EXTERNAL_ADDRESS_BUS,
  output logic [15:0]      EXTERNAL_DATA_BUS_O,
  input  wire logic [15:0] EXTERNAL_DATA_BUS_I,
  output logic             EXTERNAL_DATA_BUS_OE_N,
  input  wire logic        EXTERNAL_READY_IN
);

  logic [3:0]  ctrl;
  logic [13:0] timing;
  logic [18:0] cfg_addr;
  logic [15:0] cfg_wdata;
  logic        start;
  logic        start_wr;
  logic [7:0]  status;

  ebs_state_t  state_r;
  ebs_state_t  state_nxt;
  logic        div_r;
  logic        hp_r;
  logic        hp_nxt;
  logic        clk_r;
  logic        clk_nxt;
  logic        req_r;
  logic        req_nxt;
  logic        reqwr_r;
  logic        reqwr_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [3:0]  ws_cnt_r;
  logic [3:0]  ws_cnt_nxt;
  logic [3:0]  ws_last_r;
  logic [3:0]  ws_last_nxt;
  logic [2:0]  seen_r;
  logic [2:0]  seen_nxt;
  logic        rel_r;
  logic        rel_nxt;
  logic        cap_r;
  logic        cap_nxt;
  logic        zone_r;
  logic        zone_nxt;
  logic        rds_r;
  logic        rds_nxt;
  logic        wrs_r;
  logic        wrs_nxt;
  logic        rnw_r;
  logic        rnw_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic [18:0] addr_r;
  logic [18:0] addr_nxt;
  logic [15:0] dout_r;
  logic [15:0] dout_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [1:0]  rdy_sync_r;
  logic [15:0] din_s1_r;
  logic [15:0] din_s2_r;

  ebs_regs u_regs (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hreadyout (HREADYOUT),
    .hrdata    (HRDATA),
    .hresp     (HRESP),
    .ctrl      (ctrl),
    .timing    (timing),
    .addr      (cfg_addr),
    .wdata     (cfg_wdata),
    .start     (start),
    .start_wr  (start_wr),
    .status    (status),
    .rdata     (rdata_r)
  );

  // The access timing clock is an enable pulse on every second system cycle.
  wire logic tick = div_r;

  wire logic half   = ctrl[`EBS_CTRL_HALF];
  wire logic honor  = ctrl[`EBS_CTRL_HONOR];
  wire logic async  = ctrl[`EBS_CTRL_ASYNC];
  wire logic double = ctrl[`EBS_CTRL_DOUBLE];
  wire logic rdy    = rdy_sync_r[1];

  // Lead, active and trail counts follow the direction of the access.
  wire logic [1:0] lead_sel = reqwr_r ? timing[`EBS_TIM_WRLEAD +: 2]
                                      : timing[`EBS_TIM_RDLEAD +: 2];
  wire logic [2:0] act_sel  = reqwr_r ? timing[`EBS_TIM_WRACT +: 3]
                                      : timing[`EBS_TIM_RDACT +: 3];
  wire logic [1:0] trl_sel  = reqwr_r ? timing[`EBS_TIM_WRTRAIL +: 2]
                                      : timing[`EBS_TIM_RDTRAIL +: 2];

  wire logic [2:0] lead_eff = double ? {lead_sel, 1'b0} : {1'b0, lead_sel};
  wire logic [3:0] act_eff  = (double ? {act_sel, 1'b0} : {1'b0, act_sel})
                              + 4'h1;
  wire logic [2:0] trl_eff  = double ? {trl_sel, 1'b0} : {1'b0, trl_sel};

  // A zero lead count is illegal; it behaves as a lead of one cycle.
  wire logic [3:0] lead_ld  = (lead_eff == 3'h0) ? 4'h1 : {1'b0, lead_eff};
  wire logic [3:0] trl_ld   = {1'b0, trl_eff};
  wire logic [3:0] cnt_dec  = cnt_r - 4'h1;
  wire logic       cnt_last = cnt_r == 4'h1;

  // Ready is sampled on every tick from the first sample on; the asynchronous
  // style decides on the sample taken three ticks back, the other on the last.
  wire logic [3:0] smp_tgt  = async ? `EBS_ASYNC_SMP : `EBS_SYNC_SMP;
  wire logic       smp_entry = act_eff <= smp_tgt;
  wire logic       smp_now  = cnt_dec <= smp_tgt;
  wire logic       ready_ok = ~honor | (async ? seen_r[2] : seen_r[0]);

  // In half rate a new output clock period opens on ticks with the phase low.
  wire logic       can_start = ~half | ~hp_r;
  wire logic       trl_none  = trl_eff == 3'h0;
  wire logic       busy      = req_r | (state_r != EBS_IDLE);
  wire logic [3:0] ws_inc    = ws_cnt_r + 4'h1;

  assign status = {ws_last_r, state_r, hp_r, busy};

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    ws_cnt_nxt  = ws_cnt_r;
    ws_last_nxt = ws_last_r;
    seen_nxt    = seen_r;
    rel_nxt     = rel_r;
    cap_nxt     = cap_r;
    zone_nxt    = zone_r;
    rds_nxt     = rds_r;
    wrs_nxt     = wrs_r;
    rnw_nxt     = rnw_r;
    oe_nxt      = oe_r;
    addr_nxt    = addr_r;
    dout_nxt    = dout_r;
    rdata_nxt   = rdata_r;
    req_nxt     = req_r | start;
    reqwr_nxt   = start ? start_wr : reqwr_r;
    hp_nxt      = hp_r;
    clk_nxt     = half ? clk_r : 1'b0;
    if (tick) begin
      hp_nxt  = ~hp_r;
      clk_nxt = half ? ~hp_r : 1'b1;
      // The data bus is let go one tick after the write flag went high.
      if (rel_r) begin
        oe_nxt  = 1'b1;
        rel_nxt = 1'b0;
      end
      // Read data are taken one tick after the release, so the pin value at
      // the release edge has passed both synchroniser flops.
      if (cap_r) begin
        rdata_nxt = din_s2_r;
        cap_nxt   = 1'b0;
      end
      unique case (state_r)
        EBS_IDLE: begin
          if (req_r && can_start) begin
            state_nxt  = EBS_LEAD;
            req_nxt    = 1'b0;
            zone_nxt   = 1'b0;
            rnw_nxt    = ~reqwr_r;
            addr_nxt   = cfg_addr;
            dout_nxt   = cfg_wdata;
            cnt_nxt    = lead_ld;
            ws_cnt_nxt = 4'h0;
          end else begin
            zone_nxt = 1'b1;
            rds_nxt  = 1'b1;
            wrs_nxt  = 1'b1;
            rnw_nxt  = 1'b1;
          end
        end
        EBS_LEAD: begin
          if (cnt_last) begin
            state_nxt = EBS_ACTIVE;
            cnt_nxt   = act_eff;
            seen_nxt  = smp_entry ? {3{rdy}} : 3'h0;
            if (reqwr_r) begin
              wrs_nxt = 1'b0;
              oe_nxt  = 1'b0;
            end else begin
              rds_nxt = 1'b0;
            end
          end else begin
            cnt_nxt = cnt_dec;
          end
        end
        EBS_ACTIVE: begin
          if (!cnt_last) begin
            cnt_nxt = cnt_dec;
            if (smp_now) begin
              seen_nxt = {seen_r[1:0], rdy};
            end
          end else if (ready_ok) begin
            rds_nxt     = 1'b1;
            wrs_nxt     = 1'b1;
            ws_last_nxt = ws_cnt_r;
            cap_nxt     = ~reqwr_r;
            if (trl_none) begin
              state_nxt = EBS_IDLE;
              zone_nxt  = 1'b1;
              rnw_nxt   = 1'b1;
              rel_nxt   = reqwr_r;
            end else begin
              state_nxt = EBS_TRAIL;
              cnt_nxt   = trl_ld;
            end
          end else begin
            // Wait state: ready is sampled again on each timing cycle.
            seen_nxt   = {seen_r[1:0], rdy};
            ws_cnt_nxt = ws_inc;
          end
        end
        EBS_TRAIL: begin
          // Write data stay on the bus while the trail runs.
          if (cnt_last) begin
            state_nxt = EBS_IDLE;
            zone_nxt  = 1'b1;
            rnw_nxt   = 1'b1;
            rel_nxt   = reqwr_r;
          end else begin
            cnt_nxt = cnt_dec;
          end
        end
      endcase
    end
  end

  // Pin inputs pass two flops before any logic reads them.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rdy_sync_r <= 2'h0;
      din_s1_r   <= 16'h0000;
      din_s2_r   <= 16'h0000;
    end else begin
      rdy_sync_r <= {rdy_sync_r[0], EXTERNAL_READY_IN};
      din_s1_r   <= EXTERNAL_DATA_BUS_I;
      din_s2_r   <= din_s1_r;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      div_r   <= 1'b0;
      hp_r    <= 1'b0;
      clk_r   <= 1'b0;
      req_r   <= 1'b0;
      reqwr_r <= 1'b0;
    end else begin
      div_r   <= ~div_r;
      hp_r    <= hp_nxt;
      clk_r   <= clk_nxt;
      req_r   <= req_nxt;
      reqwr_r <= reqwr_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_r   <= EBS_IDLE;
      cnt_r     <= 4'h0;
      ws_cnt_r  <= 4'h0;
      ws_last_r <= 4'h0;
      seen_r    <= 3'h0;
      rel_r     <= 1'b0;
      cap_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      ws_cnt_r  <= ws_cnt_nxt;
      ws_last_r <= ws_last_nxt;
      seen_r    <= seen_nxt;
      rel_r     <= rel_nxt;
      cap_r     <= cap_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      zone_r  <= 1'b1;
      rds_r   <= 1'b1;
      wrs_r   <= 1'b1;
      rnw_r   <= 1'b1;
      oe_r    <= 1'b1;
      addr_r  <= 19'h0_0000;
      dout_r  <= 16'h0000;
      rdata_r <= 16'h0000;
    end else begin
      zone_r  <= zone_nxt;
      rds_r   <= rds_nxt;
      wrs_r   <= wrs_nxt;
      rnw_r   <= rnw_nxt;
      oe_r    <= oe_nxt;
      addr_r  <= addr_nxt;
      dout_r  <= dout_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign OUTPUT_BUS_CLOCK       = clk_r;
  assign ZONE_SELECT_N          = zone_r;
  assign READ_STROBE_N          = rds_r;
  assign WRITE_STROBE_N         = wrs_r;
  assign READ_NOT_WRITE         = rnw_r;
  assign EXTERNAL_ADDRESS_BUS   = addr_r;
  assign EXTERNAL_DATA_BUS_O    = dout_r;
  assign EXTERNAL_DATA_BUS_OE_N = oe_r;

endmodule

`default_nettype wire

// *** design/ebs_defs.svh ***
/*
  Offsets, field positions, reset values and timing counts of the
  external bus strobe sequencer.
  Assumes inclusion by bare name from the design files.
*/
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH

`define EBS_OFF_CTRL    8'h00
`define EBS_OFF_TIMING  8'h04
`define EBS_OFF_ADDR    8'h08
`define EBS_OFF_WDATA   8'h0C
`define EBS_OFF_CMD     8'h10
`define EBS_OFF_STATUS  8'h14
`define EBS_OFF_RDATA   8'h18

`define EBS_CTRL_HALF   0
`define EBS_CTRL_HONOR  1
`define EBS_CTRL_ASYNC  2
`define EBS_CTRL_DOUBLE 3

`define EBS_TIM_RDLEAD  0
`define EBS_TIM_RDACT   2
`define EBS_TIM_RDTRAIL 5
`define EBS_TIM_WRLEAD  7
`define EBS_TIM_WRACT   9
`define EBS_TIM_WRTRAIL 12

`define EBS_CTRL_RST    4'h0
`define EBS_TIMING_RST  14'h3F7F
`define EBS_SYNC_SMP    4'h1
`define EBS_ASYNC_SMP   4'h3

`endif

// *** design/ebs_pkg.sv ***
/*
  Types shared by the external bus strobe sequencer.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package ebs_pkg;

  typedef enum logic [1:0] {
    EBS_IDLE,
    EBS_LEAD,
    EBS_ACTIVE,
    EBS_TRAIL
  } ebs_state_t;

endpackage

`default_nettype wire

// *** design/ebs_regs.sv ***
/*
  AHB-Lite slave holding the sequencer registers.
  Assumes one master, word transfers, and a busy flag from the sequencer.
*/
`default_nettype none
`include "ebs_defs.svh"

module ebs_regs
  import ebs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [3:0]       ctrl,
  output logic [13:0]      timing,
  output logic [18:0]      addr,
  output logic [15:0]      wdata,
  output logic             start,
  output logic             start_wr,
  input  wire logic [7:0]  status,
  input  wire logic [15:0] rdata
);

  logic [7:0] a_r;
  logic       w_r;
  logic       hit_r;
  logic       p_r;

  // Every transfer takes one wait state so that read data leave a flop.
  wire logic        acc    = hsel & htrans[1] & hready;
  wire logic        wr_en  = p_r & w_r & hit_r;
  wire logic        s_ctrl = a_r == `EBS_OFF_CTRL;
  wire logic        s_tim  = a_r == `EBS_OFF_TIMING;
  wire logic        s_addr = a_r == `EBS_OFF_ADDR;
  wire logic        s_wdat = a_r == `EBS_OFF_WDATA;
  wire logic        s_cmd  = a_r == `EBS_OFF_CMD;
  wire logic        s_stat = a_r == `EBS_OFF_STATUS;
  wire logic        s_rdat = a_r == `EBS_OFF_RDATA;
  wire logic [31:0] rd_mux =
    !hit_r ? 32'h0000_0000 :
    s_ctrl ? {28'h000_0000, ctrl} :
    s_tim  ? {18'h0_0000, timing} :
    s_addr ? {13'h0000, addr} :
    s_wdat ? {16'h0000, wdata} :
    s_stat ? {24'h00_0000, status} :
    s_rdat ? {16'h0000, rdata} :
    32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_r       <= 8'h00;
      w_r       <= 1'b0;
      hit_r     <= 1'b0;
      p_r       <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
      start     <= 1'b0;
      start_wr  <= 1'b0;
    end else begin
      p_r       <= acc;
      hreadyout <= ~acc;
      hresp     <= 1'b0;
      start     <= wr_en & s_cmd & ~status[0];
      if (acc) begin
        a_r   <= haddr[7:0];
        w_r   <= hwrite & (hsize == 3'h2);
        hit_r <= (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'h0);
      end
      if (p_r) begin
        hrdata <= rd_mux;
      end
      if (wr_en & s_cmd & ~status[0]) begin
        start_wr <= hwdata[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl   <= `EBS_CTRL_RST;
      timing <= `EBS_TIMING_RST;
      addr   <= 19'h0_0000;
      wdata  <= 16'h0000;
    end else if (wr_en) begin
      if (s_ctrl) ctrl <= hwdata[3:0];
      if (s_tim) timing <= hwdata[13:0];
      if (s_addr) addr <= hwdata[18:0];
      if (s_wdat) wdata <= hwdata[15:0];
    end
  end

endmodule

`default_nettype wire

// *** verif/ebs_seq_checker.sv ***
/*
  Pin and bus assertions for the strobe sequencer.
  Assumes a bind to ebs_seq with HREADY tied to HREADYOUT.
*/
`default_nettype none
`include "ebs_defs.svh"

module ebs_seq_checker (
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        OUTPUT_BUS_CLOCK,
  input wire logic        ZONE_SELECT_N,
  input wire logic        READ_STROBE_N,
  input wire logic        WRITE_STROBE_N,
  input wire logic        READ_NOT_WRITE,
  input wire logic [18:0] EXTERNAL_ADDRESS_BUS,
  input wire logic [15:0] EXTERNAL_DATA_BUS_O,
  input wire logic        EXTERNAL_DATA_BUS_OE_N
);
  logic ctl_r;
  logic half_r;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // Tracks the half rate bit written over the register bus.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctl_r  <= 1'b0;
      half_r <= 1'b0;
    end else if (HREADY) begin
      ctl_r <= HSEL && HTRANS[1] && HWRITE && (HADDR == 32'h0000_0000);
      if (ctl_r) half_r <= HWDATA[`EBS_CTRL_HALF];
    end
  end

  AST_ON_TICK: assert property (
    ($changed(READ_STROBE_N) || $changed(WRITE_STROBE_N) || $changed(ZONE_SELECT_N))
    |-> $changed(OUTPUT_BUS_CLOCK)) else $error("strobe moved off a bus clock edge");
  AST_FULL_RISE: assert property (
    !half_r && ($changed(READ_STROBE_N) || $changed(WRITE_STROBE_N)
    || $changed(ZONE_SELECT_N)) |-> $rose(OUTPUT_BUS_CLOCK)) else $error("full rate off rise");
  AST_START_RISE: assert property (
    $fell(ZONE_SELECT_N) |-> $rose(OUTPUT_BUS_CLOCK)) else $error("zone low off rise");
  AST_RNW_START: assert property (
    $fell(READ_NOT_WRITE) |-> $fell(ZONE_SELECT_N)) else $error("write flag off start");
  AST_IDLE_QUIET: assert property (
    ZONE_SELECT_N |-> READ_STROBE_N && WRITE_STROBE_N && READ_NOT_WRITE)
    else $error("control active while idle");
  AST_ADDR_HOLD: assert property (
    ZONE_SELECT_N |-> $stable(EXTERNAL_ADDRESS_BUS)) else $error("address moved while idle");
  AST_OE_WITH_WE: assert property (
    $fell(WRITE_STROBE_N) |-> $fell(EXTERNAL_DATA_BUS_OE_N)) else $error("drive not at strobe");
  AST_OE_RELEASE: assert property (
    $rose(READ_NOT_WRITE) |-> !EXTERNAL_DATA_BUS_OE_N ##1 !EXTERNAL_DATA_BUS_OE_N
    ##1 EXTERNAL_DATA_BUS_OE_N) else $error("data release timing");
  AST_DATA_HOLD: assert property (
    !EXTERNAL_DATA_BUS_OE_N |-> $stable(EXTERNAL_DATA_BUS_O)) else $error("write data moved");
  AST_MIN_ACCESS: assert property (
    $fell(ZONE_SELECT_N) |-> !ZONE_SELECT_N [*4]) else $error("access too short");
  AST_AHB_WAIT: assert property (
    HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT) else $error("bus wait length");

  CV_WRITE: cover property ($fell(WRITE_STROBE_N));
  CV_READ: cover property ($fell(READ_STROBE_N));
  CV_HALF: cover property (half_r && $fell(ZONE_SELECT_N));
endmodule

bind ebs_seq ebs_seq_checker u_chk (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .OUTPUT_BUS_CLOCK(OUTPUT_BUS_CLOCK), .ZONE_SELECT_N(ZONE_SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
  .READ_NOT_WRITE(READ_NOT_WRITE), .EXTERNAL_ADDRESS_BUS(EXTERNAL_ADDRESS_BUS),
  .EXTERNAL_DATA_BUS_O(EXTERNAL_DATA_BUS_O),
  .EXTERNAL_DATA_BUS_OE_N(EXTERNAL_DATA_BUS_OE_N)
);

`default_nettype wire

// *** verif/ebs_mem_model.sv ***
/*
  Small asynchronous memory on the external bus.
  Assumes the bench resolves the data pin and sets the ready delay.
*/
`default_nettype none

module ebs_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        zone_n,
  input  wire logic        rd_n,
  input  wire logic        we_n,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] din,
  input  wire logic [7:0]  dly,
  output logic [15:0]      dout,
  output logic             rdy
);
  logic [15:0] mem [16];
  logic [15:0] last_r;
  logic [7:0]  cnt_r;
  logic        we_d_r;

  // Released data shows the inverse of the last value.
  assign dout = rd_n ? ~last_r : mem[addr[3:0]];
  // Ready rises a set number of cycles into the access; all ones never.
  assign rdy = (dly != 8'hff) && (cnt_r >= dly);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r <= 16'h0000;
      cnt_r  <= 8'h00;
      we_d_r <= 1'b1;
    end else begin
      cnt_r  <= zone_n ? 8'h00 : cnt_r + 8'h01;
      we_d_r <= we_n;
      if (!rd_n) last_r <= dout;
      if (we_n && !we_d_r) mem[addr[3:0]] <= din;
    end
  end
endmodule

`default_nettype wire

// *** verif/ebs_seq_bench.sv ***
/*
  Self-checking bench for the strobe sequencer.
  Assumes the design files, the checker and the memory model.
*/
`default_nettype none
`include "ebs_defs.svh"

module ebs_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        CLK_SYS = 1'b0;
  logic        RST_B;
  logic        HSEL, HWRITE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic        HREADYOUT, HRESP, OUTPUT_BUS_CLOCK, ZONE_SELECT_N;
  logic        READ_STROBE_N, WRITE_STROBE_N, READ_NOT_WRITE, oe_n, rdy;
  logic [18:0] EXTERNAL_ADDRESS_BUS;
  logic [15:0] dato, mdo;
  wire  [15:0] xd;
  logic [7:0]  dly;
  logic [31:0] seed = 32'h0000_b2b6;
  int          n_fail = 0;
  int          num_checks = 0;

  assign xd = !oe_n ? dato : mdo;

  ebs_seq uut (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
    .OUTPUT_BUS_CLOCK(OUTPUT_BUS_CLOCK), .ZONE_SELECT_N(ZONE_SELECT_N),
    .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
    .READ_NOT_WRITE(READ_NOT_WRITE), .EXTERNAL_ADDRESS_BUS(EXTERNAL_ADDRESS_BUS),
    .EXTERNAL_DATA_BUS_O(dato), .EXTERNAL_DATA_BUS_I(xd),
    .EXTERNAL_DATA_BUS_OE_N(oe_n), .EXTERNAL_READY_IN(rdy)
  );

  ebs_mem_model mem (
    .clk(CLK_SYS), .rst_b(RST_B), .zone_n(ZONE_SELECT_N), .rd_n(READ_STROBE_N),
    .we_n(WRITE_STROBE_N), .addr(EXTERNAL_ADDRESS_BUS), .din(xd), .dly(dly),
    .dout(mdo), .rdy(rdy)
  );

  always #12.5 CLK_SYS = ~CLK_SYS;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Bus clock level just after a change that many ticks into an access.
  function automatic logic lvl(input logic h, input int n);
    return h ? ~n[0] : 1'b1;
  endfunction

  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= 32'(a);
    HWRITE <= w;
    HSIZE <= 3'h2;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    q = HRDATA;
    chk(HRESP, 1'b0, "response");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk(q, e, "register");
  endtask

  task automatic acc(input logic w, input logic [3:0] cf, input logic [6:0] tv,
                     input logic [18:0] a, input logic [15:0] d, output int ws);
    int c, tz, ts, te, tr, l, ac, t, k;
    logic stb, ce, cr;
    logic [31:0] q;
    k = cf[`EBS_CTRL_DOUBLE] ? 2 : 1;
    l = k * tv[1:0];
    ac = k * tv[4:2];
    t = k * tv[6:5];
    tz = -1;
    ts = -1;
    te = -1;
    tr = -1;
    wr(`EBS_OFF_CTRL, 32'(cf));
    wr(`EBS_OFF_TIMING, 32'({tv, tv}));
    wr(`EBS_OFF_ADDR, 32'(a));
    wr(`EBS_OFF_WDATA, 32'(d));
    wr(`EBS_OFF_CMD, 32'(w));
    for (c = 0; c < 600 && tr < 0; c++) begin
      @(posedge CLK_SYS);
      #1;
      stb = w ? WRITE_STROBE_N : READ_STROBE_N;
      if (tz < 0 && ZONE_SELECT_N === 1'b0) begin
        tz = c;
        chk(EXTERNAL_ADDRESS_BUS, a, "address");
        chk(OUTPUT_BUS_CLOCK, 1'b1, "start edge");
        chk(READ_NOT_WRITE, !w, "direction");
      end
      if (tz >= 0 && ts < 0 && stb === 1'b0) begin
        ts = c;
        chk(c - tz, 2 * l, "lead");
        chk(OUTPUT_BUS_CLOCK, lvl(cf[0], l), "strobe edge");
      end
      if (ts >= 0 && te < 0 && stb === 1'b1) begin
        te = c;
        ce = OUTPUT_BUS_CLOCK;
      end
      if (tz >= 0 && tr < 0 && ZONE_SELECT_N === 1'b1) begin
        tr = c;
        cr = OUTPUT_BUS_CLOCK;
        if (w) chk(oe_n, 1'b0, "drive at end");
        if (w) chk(dato, d, "write data");
      end
    end
    @(posedge CLK_SYS);
    ahb(1'b0, `EBS_OFF_STATUS, 32'h0000_0000, q);
    ws = q[7:4];
    chk(tr >= 0, 1'b1, "access end");
    chk(te - ts, 2 * (ac + 1 + ws), "active");
    chk(tr - te, 2 * t, "trail");
    chk(ce, lvl(cf[0], l + ac + 1 + ws), "release edge");
    chk(cr, lvl(cf[0], l + ac + 1 + ws + t), "end edge");
    if (!cf[`EBS_CTRL_HONOR]) chk(ws, 0, "waits");
    chk(EXTERNAL_ADDRESS_BUS, a, "address held");
    if (!w) rd(`EBS_OFF_RDATA, 32'(d));
  endtask

  initial begin
    #500_000;
    n_fail++;
    complete_run();
  end

  initial begin
    int i, wa, wb;
    logic [31:0] r, d;
    logic [3:0]  cf;
    RST_B = 1'b0;
    HSEL = 1'b0;
    HWRITE = 1'b0;
    HADDR = 32'h0000_0000;
    HWDATA = 32'h0000_0000;
    HTRANS = 2'b00;
    HSIZE = 3'h2;
    dly = 8'hff;
    repeat (20) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    @(posedge CLK_SYS);
    rd(`EBS_OFF_CTRL, 32'(`EBS_CTRL_RST));
    rd(`EBS_OFF_TIMING, 32'(`EBS_TIMING_RST));
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_0000);
    acc(1'b1, 4'h0, 7'b01_000_01, 19'h7_fff0, 16'ha5c3, wa);
    acc(1'b0, 4'h0, 7'b01_000_01, 19'h7_fff0, 16'ha5c3, wa);
    for (i = 0; i < 20; i++) begin
      r = rnd();
      d = rnd();
      cf = r[3:0];
      dly <= cf[`EBS_CTRL_HONOR] ? 8'(r[15:12]) : 8'hff;
      acc(1'b1, cf, {r[5:4], (r[8:6] == 3'h0) ? 3'h1 : r[8:6],
          (r[10:9] == 2'h0) ? 2'h1 : r[10:9]}, r[31:13], d[15:0], wa);
      acc(1'b0, cf, {r[5:4], 3'h2, 2'h1}, r[31:13], d[15:0], wa);
    end
    dly <= 8'h14;
    acc(1'b0, 4'b0010, 7'b01_011_10, r[31:13], d[15:0], wa);
    acc(1'b0, 4'b0110, 7'b01_011_10, r[31:13], d[15:0], wb);
    chk(wa > 0, 1'b1, "sync waits");
    chk(wb, wa + 2, "async waits");
    complete_run();
  end
endmodule

`default_nettype wire
